// >>> include/shph_pkg.sv
// shared constants and types of the host serial port
package shph_pkg;
    localparam int CLK_HZ          = 20_000_000;
    // inter-command timeout, least time, so rounded up
    localparam int SEQ_TIMEOUT_US  = 100;
    localparam int SEQ_TIMEOUT_CYC = (SEQ_TIMEOUT_US * CLK_HZ + 999_999) / 1_000_000;
    localparam logic [11:0] TO_LAST = 12'(SEQ_TIMEOUT_CYC - 1);

    // chain bit clock rates
    localparam int CHAIN_FAST_HZ = 1_000_000;
    localparam int CHAIN_MID_HZ  = 500_000;
    localparam int CHAIN_SLOW_HZ = 333_000;
    localparam logic [7:0] DIV_FAST = 8'(CLK_HZ / CHAIN_FAST_HZ);
    localparam logic [7:0] DIV_MID  = 8'(CLK_HZ / CHAIN_MID_HZ);
    localparam logic [7:0] DIV_SLOW = 8'(CLK_HZ / CHAIN_SLOW_HZ);

    // packet reset after this many idle chain bit periods
    localparam int PKT_IDLE_TICKS = 3;
    localparam logic [1:0] PKT_IDLE = 2'(PKT_IDLE_TICKS);

    localparam int BYTE_BITS = 8;
    localparam logic [2:0] LAST_BIT = 3'(BYTE_BITS - 1);
    localparam logic [7:0] TX_FILL  = 8'h00;
    localparam int TX_DEPTH = 2;

    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_DRIVE    = 2'b01,
        ST_RELEASED = 2'b10
    } shph_state_e;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
        logic sel1;
        logic sel0;
    } shph_pins_s;
endpackage

// >>> design/shph_fifo.sv
// small valid/ready buffer for response bytes
`timescale 1ns/10ps
`default_nettype none
module shph_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    input  wire logic         flush_i,
    // fill side
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    // drain side
    output logic [W-1:0]      out_data_o,
    output logic              out_valid_o,
    input  wire logic         out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [CW-1:0] cnt_reg;

    wire push = in_valid_i & in_ready_o;
    wire pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = (cnt_reg != CW'(DEPTH));
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o  = mem_reg[rd_ptr_reg];

    function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
        inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i || flush_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= inc(wr_ptr_reg);
            end
            if (pop) begin
                rd_ptr_reg <= inc(rd_ptr_reg);
            end
            cnt_reg <= cnt_reg + CW'(push) - CW'(pop);
        end
    end
endmodule
`default_nettype wire

// >>> design/shph_port.sv
// host serial port with response pacing, timeout and chain rate divider
`timescale 1ns/10ps
`default_nettype none
module shph_port #(
    parameter int TX_DEPTH = shph_pkg::TX_DEPTH
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    // serial pins
    input  wire logic       spi_cs_n_i,
    input  wire logic       spi_sclk_i,
    input  wire logic       spi_din_i,
    output logic            spi_dout_o,
    output logic            spi_dout_oe_o,
    output logic            response_pending_n_o,
    // strap pins
    input  wire logic       link_rate_sel0_i,
    input  wire logic       link_rate_sel1_i,
    // mode
    input  wire logic       block_mode_i,
    // response bytes
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_valid_i,
    output logic            tx_ready_o,
    // received bytes
    output logic [7:0]      rx_data_o,
    output logic            rx_valid_o,
    output logic            seq_timeout_o,
    // chain side
    input  wire logic       chain_activity_i,
    output logic            chain_bit_tick_o,
    output logic            chain_packet_reset_o
);
    shph_pkg::shph_pins_s sync1_reg;
    shph_pkg::shph_pins_s sync2_reg;
    shph_pkg::shph_pins_s pins_w;
    shph_pkg::shph_state_e state_reg;
    shph_pkg::shph_state_e state_next;

    logic       sclk_hist_reg;
    logic       din_hist_reg;
    logic       sclk_filt_reg;
    logic       din_filt_reg;
    logic       sclk_prev_reg;
    logic       cs_prev_reg;
    logic [2:0] rise_cnt_reg;
    logic [2:0] fall_cnt_reg;
    logic [6:0] rx_shift_reg;
    logic [7:0] tx_shift_reg;
    logic [7:0] rx_data_reg;
    logic       rx_valid_reg;
    logic       pend_reg;
    logic       pend_next;
    logic       seq_reg;
    logic [11:0] to_cnt_reg;
    logic [7:0] div_cnt_reg;
    logic       tick_reg;
    logic [1:0] idle_cnt_reg;
    logic       pkt_rst_reg;
    logic [7:0] fifo_data;
    logic       fifo_valid;

    assign pins_w = '{cs_n: spi_cs_n_i, sclk: spi_sclk_i, din: spi_din_i,
                      sel1: link_rate_sel1_i, sel0: link_rate_sel0_i};

    // edge and event decode
    wire cs_high    = sync2_reg.cs_n;
    wire cs_fall    = ~sync2_reg.cs_n & cs_prev_reg;
    wire cs_rise    = sync2_reg.cs_n & ~cs_prev_reg;
    wire sclk_rise  = sclk_filt_reg & ~sclk_prev_reg;
    wire sclk_fall  = ~sclk_filt_reg & sclk_prev_reg;
    wire active     = ~cs_high & ~cs_fall;
    wire byte_rx    = active & sclk_rise & (rise_cnt_reg == shph_pkg::LAST_BIT);
    wire byte_end   = active & sclk_fall & (fall_cnt_reg == shph_pkg::LAST_BIT)
                      & (state_reg == shph_pkg::ST_DRIVE);
    wire chain_next = block_mode_i & fifo_valid;
    wire tx_pop     = fifo_valid & (cs_fall | (byte_end & block_mode_i));
    wire to_hit     = seq_reg & cs_high & (to_cnt_reg == shph_pkg::TO_LAST);
    wire [1:0] sel_code = {sync2_reg.sel1, sync2_reg.sel0};
    // 2'b01 is not a listed strap setting; it falls back to the fastest rate
    wire [7:0] div_sel = (sel_code == 2'b10) ? shph_pkg::DIV_MID :
                         (sel_code == 2'b00) ? shph_pkg::DIV_SLOW : shph_pkg::DIV_FAST;

    // two-flop synchronisers on every pin
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync1_reg <= '{cs_n: 1'b1, default: 1'b0};
            sync2_reg <= '{cs_n: 1'b1, default: 1'b0};
        end else begin
            sync1_reg <= pins_w;
            sync2_reg <= sync1_reg;
        end
    end

    // a level must hold two samples to pass, so single-cycle spikes are dropped
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sclk_hist_reg <= 1'b0;
            din_hist_reg  <= 1'b0;
            sclk_filt_reg <= 1'b0;
            din_filt_reg  <= 1'b0;
            sclk_prev_reg <= 1'b0;
            cs_prev_reg   <= 1'b1;
        end else begin
            sclk_hist_reg <= sync2_reg.sclk;
            din_hist_reg  <= sync2_reg.din;
            if (sync2_reg.sclk == sclk_hist_reg) begin
                sclk_filt_reg <= sclk_hist_reg;
            end
            if (sync2_reg.din == din_hist_reg) begin
                din_filt_reg <= din_hist_reg;
            end
            sclk_prev_reg <= sclk_filt_reg;
            cs_prev_reg   <= sync2_reg.cs_n;
        end
    end

    // receive shifter
    always_ff @(posedge clk_i) begin
        if (reset_i || cs_fall) begin
            rise_cnt_reg <= 3'h0;
            rx_valid_reg <= 1'b0;
        end else begin
            rx_valid_reg <= byte_rx;
            if (active && sclk_rise) begin
                rise_cnt_reg <= rise_cnt_reg + 3'h1;
                rx_shift_reg <= {rx_shift_reg[5:0], din_filt_reg};
            end
            if (byte_rx) begin
                rx_data_reg <= {rx_shift_reg, din_filt_reg};
            end
        end
    end

    // transmit shifter, msb leads
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            fall_cnt_reg <= 3'h0;
            tx_shift_reg <= shph_pkg::TX_FILL;
        end else if (cs_fall) begin
            fall_cnt_reg <= 3'h0;
            tx_shift_reg <= fifo_valid ? fifo_data : shph_pkg::TX_FILL;
        end else if (active && sclk_fall) begin
            fall_cnt_reg <= fall_cnt_reg + 3'h1;
            if (byte_end && chain_next) begin
                tx_shift_reg <= fifo_data;
            end else begin
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end
        end
    end

    // output driver state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            shph_pkg::ST_IDLE: begin
                if (cs_fall) begin
                    state_next = shph_pkg::ST_DRIVE;
                end
            end
            shph_pkg::ST_DRIVE: begin
                if (cs_high) begin
                    state_next = shph_pkg::ST_IDLE;
                end else if (byte_end && !chain_next) begin
                    state_next = shph_pkg::ST_RELEASED;
                end
            end
            shph_pkg::ST_RELEASED: begin
                if (cs_high) begin
                    state_next = shph_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = shph_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= shph_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ready line: abort first, then set while idle, then clears
    always_comb begin
        pend_next = pend_reg;
        if (to_hit || !seq_reg) begin
            pend_next = 1'b0;
        end else if (cs_high && fifo_valid) begin
            pend_next = 1'b1;
        end else if (cs_fall && !block_mode_i) begin
            pend_next = 1'b0;
        end else if (byte_end && block_mode_i && !fifo_valid) begin
            pend_next = 1'b0;
        end
    end

    // sequence tracking and inter-command timeout
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pend_reg   <= 1'b0;
            seq_reg    <= 1'b0;
            to_cnt_reg <= 12'h000;
        end else begin
            pend_reg <= pend_next;
            if (cs_fall) begin
                seq_reg <= 1'b1;
            end else if (to_hit) begin
                seq_reg <= 1'b0;
            end
            if (!cs_high || !seq_reg) begin
                to_cnt_reg <= 12'h000;
            end else begin
                to_cnt_reg <= to_cnt_reg + 12'h001;
            end
        end
    end

    // chain bit clock divider and idle packet reset
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            div_cnt_reg  <= 8'h00;
            tick_reg     <= 1'b0;
            idle_cnt_reg <= 2'h0;
            pkt_rst_reg  <= 1'b0;
        end else begin
            tick_reg    <= (div_cnt_reg == 8'h00);
            div_cnt_reg <= (div_cnt_reg == 8'h00) ? div_sel - 8'h01 : div_cnt_reg - 8'h01;
            pkt_rst_reg <= 1'b0;
            if (chain_activity_i) begin
                idle_cnt_reg <= 2'h0;
            end else if (tick_reg && idle_cnt_reg != shph_pkg::PKT_IDLE) begin
                idle_cnt_reg <= idle_cnt_reg + 2'h1;
                pkt_rst_reg  <= (idle_cnt_reg == shph_pkg::PKT_IDLE - 2'h1);
            end
        end
    end

    // response bytes; a timeout throws away what was queued for the dead sequence
    shph_fifo #(
        .W     (8),
        .DEPTH (TX_DEPTH)
    ) u_tx_fifo (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .flush_i     (to_hit),
        .in_data_i   (tx_data_i),
        .in_valid_i  (tx_valid_i),
        .in_ready_o  (tx_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (tx_pop)
    );

    assign spi_dout_o           = tx_shift_reg[7];
    assign spi_dout_oe_o        = (state_reg == shph_pkg::ST_DRIVE);
    assign response_pending_n_o = ~pend_reg;
    assign rx_data_o            = rx_data_reg;
    assign rx_valid_o           = rx_valid_reg;
    assign seq_timeout_o        = to_hit;
    assign chain_bit_tick_o     = tick_reg;
    assign chain_packet_reset_o = pkt_rst_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    chk_dout_after_fall: assert property (
        spi_dout_oe_o && $past(spi_dout_oe_o) && $changed(spi_dout_o) |-> $past(sclk_fall))
        else $error("serial output moved without a falling clock edge");
    chk_oe_cs_low: assert property (
        spi_dout_oe_o |-> !cs_prev_reg)
        else $error("serial output driven while chip select high");
    chk_oe_on_cs_fall: assert property (
        cs_fall |=> spi_dout_oe_o [*1] ##0 (rise_cnt_reg == 3'h0))
        else $error("serial output not enabled after chip select fall");
    chk_release_last: assert property (
        byte_end && !chain_next |=> !spi_dout_oe_o until cs_fall)
        else $error("serial output still driven after final byte");
    chk_pend_set: assert property (
        seq_reg && cs_high && fifo_valid && !to_hit |=> !response_pending_n_o)
        else $error("ready line not lowered with data pending");
    chk_pend_cause: assert property (
        $fell(response_pending_n_o) |-> $past(fifo_valid) && $past(cs_high))
        else $error("ready line lowered without pending data");
    chk_block_stop: assert property (
        byte_end && block_mode_i && !fifo_valid |=> response_pending_n_o)
        else $error("ready line not raised after final block byte");
    chk_timeout_end: assert property (
        seq_timeout_o |=> response_pending_n_o && !seq_reg && !fifo_valid)
        else $error("sequence not abandoned on timeout");
    chk_timeout_wait: assert property (
        cs_fall |=> !seq_timeout_o [*8])
        else $error("timeout fired too soon after chip select fall");
    chk_rate_fast: assert property (
        chain_bit_tick_o && sel_code == 2'b11 && $stable(sel_code) |-> ##20 chain_bit_tick_o)
        else $error("fast chain bit period wrong");
    chk_pkt_reset: assert property (
        chain_packet_reset_o |-> $past(tick_reg) && !$past(chain_activity_i))
        else $error("packet reset without idle chain period");
    chk_msb_first: assert property (
        rx_valid_o |-> rx_data_o[0] == $past(din_filt_reg, 2))
        else $error("received byte not msb first");

    cov_block_end: cover property (byte_end && block_mode_i && !fifo_valid);
    cov_byte_pend: cover property (cs_rise ##[1:20] !response_pending_n_o);
    cov_timeout:   cover property (seq_timeout_o);
    cov_pkt_reset: cover property (chain_packet_reset_o);
endmodule
`default_nettype wire

// >>> verification/shph_host_model.sv
// serial master model standing in for the host controller
`timescale 1ns/10ps
`default_nettype none
module shph_host_model (
    // clock
    input  wire logic clk_i,
    // serial pins
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      din_o,
    input  wire logic miso_i,
    input  wire logic ready_n_i
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        din_o  = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic cs_low();
        cs_n_o = 1'b0;
    endtask

    // caller keeps the lag after the 8th fall; line left showing the inverse
    task automatic cs_high();
        cs_n_o = 1'b1;
        din_o  = ~din_o;
    endtask

    // 200 ns phases keep the clock at 2.5 MHz; miso taken late, just before each fall
    task automatic xfer(input logic [7:0] mosi, output logic [7:0] miso);
        for (int i = 7; i >= 0; i--) begin
            din_o = mosi[i];
            wait_cyc(4);
            sclk_o = 1'b1;
            wait_cyc(4);
            miso[i] = miso_i;
            sclk_o = 1'b0;
        end
    endtask

    // single 50 ns pulse, shorter than the input filter accepts
    task automatic spike();
        sclk_o = 1'b1;
        wait_cyc(1);
        sclk_o = 1'b0;
    endtask

    // wait for the ready line, then the host's own response delay
    task automatic await_ready(input logic lvl, input int max, output bit ok);
        ok = 1'b0;
        for (int n = 0; n <= max && !ok; n++) begin
            if (ready_n_i === lvl) ok = 1'b1;
            else wait_cyc(1);
        end
        if (ok) wait_cyc(4);
    endtask
endmodule
`default_nettype wire

// >>> verification/shph_port_test.sv
// self-checking bench of the host serial port
`timescale 1ns/10ps
`default_nettype none
module shph_port_test;
    logic       clk = 1'b0, reset_i = 1'b1, cs_n, sclk, din;
    logic       dout, dout_oe, pend_n, sel0 = 1'b1, sel1 = 1'b1, block_mode = 1'b0;
    logic [7:0] tx_data = 8'h00, rx_data, rx_last = 8'h00, got;
    logic       tx_valid = 1'b0, tx_ready, rx_valid, seq_to, activity = 1'b0, tick, pkt_rst;
    int         failures = 0, cmp_count = 0, cycles = 0, to_cnt = 0, oe_bad = 0;
    int         tick_cnt = 0, last_tick = 0, tick_gap = 0, pr_cnt = 0, pr_at = 0;
    bit         ok;
    wire logic  miso_w = dout_oe ? dout : ~dout;

    always #25 clk = ~clk;

    shph_port shph_port_i (
        .clk_i(clk), .reset_i(reset_i), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk),
        .spi_din_i(din), .spi_dout_o(dout), .spi_dout_oe_o(dout_oe),
        .response_pending_n_o(pend_n), .link_rate_sel0_i(sel0), .link_rate_sel1_i(sel1),
        .block_mode_i(block_mode), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
        .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
        .seq_timeout_o(seq_to), .chain_activity_i(activity), .chain_bit_tick_o(tick),
        .chain_packet_reset_o(pkt_rst));

    shph_host_model shph_host_model_i (
        .clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din),
        .miso_i(miso_w), .ready_n_i(pend_n));

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (rx_valid) rx_last <= rx_data;
        if (seq_to) to_cnt <= to_cnt + 1;
        if (dout_oe && cs_n) oe_bad <= oe_bad + 1;
        if (tick) begin
            tick_cnt  <= tick_cnt + 1;
            tick_gap  <= cycles - last_tick;
            last_tick <= cycles;
        end
        if (pkt_rst) begin
            pr_cnt <= pr_cnt + 1;
            pr_at  <= tick_cnt + (tick ? 1 : 0);
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // valid held across the accepting edge; one idle cycle keeps back-to-back pushes apart
    task automatic push(input logic [7:0] b);
        while (tx_ready !== 1'b1) cyc(1);
        tx_data  = b;
        tx_valid = 1'b1;
        cyc(1);
        tx_valid = 1'b0;
        cyc(1);
    endtask

    // one byte with chip select framed around it; lag of 300 ns before the rise
    task automatic byte_frame(input logic [7:0] mosi, input logic [7:0] exp);
        shph_host_model_i.cs_low();
        shph_host_model_i.xfer(mosi, got);
        check("miso_byte", got, exp);
        check("pend_in_frame", 8'(pend_n), 8'h01);
        cyc(6);
        check("oe_after_last", 8'(dout_oe), 8'h00);
        check("rx_byte", rx_last, mosi);
        shph_host_model_i.cs_high();
    endtask

    task automatic after_reset();
        check("oe_reset", 8'(dout_oe), 8'h00);
        check("pend_reset", 8'(pend_n), 8'h01);
        check("ready_reset", 8'(tx_ready), 8'h01);
    endtask

    task automatic byte_single();
        push(8'hA5);
        byte_frame(8'h3C, 8'hA5);
        cyc(8);
        check("pend_empty", 8'(pend_n), 8'h01);
    endtask

    // fill to refusal, then fetch both bytes paced by the ready line
    task automatic byte_pair();
        push(8'h11);
        push(8'h22);
        check("ready_full", 8'(tx_ready), 8'h00);
        shph_host_model_i.await_ready(1'b0, 8, ok);
        check("pend_low", 8'(ok), 8'h01);
        byte_frame(8'h81, 8'h11);
        shph_host_model_i.await_ready(1'b0, 8, ok);
        check("pend_more", 8'(ok), 8'h01);
        byte_frame(8'h7E, 8'h22);
        cyc(8);
        check("pend_done", 8'(pend_n), 8'h01);
        cyc(2);
        byte_frame(8'hF0, 8'h00);
    endtask

    // one-sample spike on the serial clock mid-frame must not count as an edge
    task automatic glitch_frame();
        push(8'h6B);
        shph_host_model_i.await_ready(1'b0, 8, ok);
        check("glitch_pend", 8'(ok), 8'h01);
        shph_host_model_i.cs_low();
        cyc(4);
        shph_host_model_i.spike();
        shph_host_model_i.xfer(8'hD2, got);
        check("glitch_miso", got, 8'h6B);
        cyc(6);
        check("glitch_rx", rx_last, 8'hD2);
        shph_host_model_i.cs_high();
    endtask

    task automatic block_pair();
        block_mode = 1'b1;
        push(8'h5A);
        push(8'hC3);
        shph_host_model_i.await_ready(1'b0, 8, ok);
        shph_host_model_i.cs_low();
        shph_host_model_i.xfer(8'h01, got);
        check("blk_first", got, 8'h5A);
        check("blk_pend_held", 8'(pend_n), 8'h00);
        shph_host_model_i.xfer(8'h02, got);
        check("blk_second", got, 8'hC3);
        shph_host_model_i.await_ready(1'b1, 8, ok);
        check("blk_pend_high", 8'(ok), 8'h01);
        check("blk_oe_off", 8'(dout_oe), 8'h00);
        check("blk_rx", rx_last, 8'h02);
        shph_host_model_i.cs_high();
        block_mode = 1'b0;
    endtask

    // cs stays high with a byte waiting: abandon, clear ready line, flush
    task automatic timeout_run();
        int t0;
        int n;
        t0 = cycles;
        push(8'h44);
        push(8'h55);
        check("to_full", 8'(tx_ready), 8'h00);
        n = to_cnt;
        for (int i = 0; i < 2200 && to_cnt == n; i++) cyc(1);
        check("to_pulse", 8'(to_cnt - n), 8'h01);
        check("to_late", 8'(cycles - t0 >= shph_pkg::SEQ_TIMEOUT_CYC), 8'h01);
        check("to_prompt", 8'(cycles - t0 <= shph_pkg::SEQ_TIMEOUT_CYC + 8), 8'h01);
        check("to_pend", 8'(pend_n), 8'h01);
        check("to_flush", 8'(tx_ready), 8'h01);
        byte_frame(8'h99, 8'h00);
        check("oe_vs_cs", 8'(oe_bad), 8'h00);
    endtask

    task automatic rates();
        logic [1:0] sel [4]  = '{2'b11, 2'b10, 2'b00, 2'b01};
        logic [7:0] per [4]  = '{shph_pkg::DIV_FAST, shph_pkg::DIV_MID,
                                 shph_pkg::DIV_SLOW, shph_pkg::DIV_FAST};
        for (int i = 0; i < 4; i++) begin
            {sel1, sel0} = sel[i];
            cyc(200);
            check("tick_period", 8'(tick_gap), per[i]);
        end
    endtask

    // slow rate so three idle periods are well apart from the activity
    task automatic packet_idle();
        int n0;
        int p0;
        {sel1, sel0} = 2'b00;
        cyc(200);
        @(posedge tick);
        cyc(10);
        activity = 1'b1;
        cyc(1);
        activity = 1'b0;
        n0 = tick_cnt;
        p0 = pr_cnt;
        cyc(600);
        check("pkt_once", 8'(pr_cnt - p0), 8'h01);
        check("pkt_third", 8'(pr_at - n0), 8'(shph_pkg::PKT_IDLE_TICKS));
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        cyc(8);
        reset_i = 1'b0;
        cyc(4);
        after_reset();
        byte_single();
        byte_pair();
        glitch_frame();
        block_pair();
        timeout_run();
        rates();
        packet_idle();
        give_verdict();
    end

    // whole run is near 4300 cycles; allow a wide margin
    initial begin
        #1_000_000;
        failures++;
        give_verdict();
    end
endmodule
`default_nettype wire
